// ### verilog/txsv_map.svh
// Purpose: offsets, field positions, reset values and limits of the tx statistics block
// Assumes: included by its bare name wherever a constant is needed
// Notes:   definitions only
`ifndef TXSV_MAP_SVH
`define TXSV_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define TXSV_CTRL_OFS      4'h0
`define TXSV_MTU_OFS       4'h4
`define TXSV_LAST_OFS      4'h8

// ----------------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------------
`define TXSV_CTRL_JUMBO    0
`define TXSV_CTRL_MTU_EN   1
`define TXSV_CTRL_VLAN_EN  2
`define TXSV_CTRL_INBAND   3
`define TXSV_CTRL_RST      4'h0
`define TXSV_MTU_RST       15'h05ee

// ----------------------------------------------------------------------
// statistics vector field positions
// ----------------------------------------------------------------------
`define TXSV_POS_PAUSE     25
`define TXSV_POS_BYTES_HI  24
`define TXSV_POS_BYTES_LO  21
`define TXSV_POS_VLAN      20
`define TXSV_POS_LEN_HI    19
`define TXSV_POS_LEN_LO    5
`define TXSV_POS_CTRL      4
`define TXSV_POS_UNDERRUN  3
`define TXSV_POS_MCAST     2
`define TXSV_POS_BCAST     1
`define TXSV_POS_GOOD      0

// ----------------------------------------------------------------------
// frame limits and type codes
// ----------------------------------------------------------------------
`define TXSV_LEN_JUMBO_MAX 15'h7fff
`define TXSV_LEN_STD_MAX   15'h05ee
`define TXSV_LEN_VLAN_MAX  15'h05f2
`define TXSV_FCS_BYTES     17'h0_0004
`define TXSV_TYPE_CTRL     16'h8808
`define TXSV_TYPE_VLAN     16'h8100
`define TXSV_TYPE_LANE     4

`endif

// ### verilog/txsv_pkg.sv
// Purpose: types shared by the tx statistics block
// Assumes: constants live in txsv_map.svh
// Notes:   structs carry grouped signals between modules
package txsv_pkg;

    // ------------------------------------------------------------------
    // transmit pipeline tap, one 64-bit beat, lane 0 sent first
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [63:0] data;
        logic [7:0]  keep;
        logic        last;
        logic        underrun;
        logic        pause_gen;
    } txsv_tap_t;

    // ------------------------------------------------------------------
    // configuration as set by software
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        jumbo_en;
        logic        mtu_en;
        logic        vlan_en;
        logic        inband_fcs;
        logic [14:0] mtu_size;
    } txsv_cfg_t;

endpackage

// ### verilog/txsv_regs.sv
// Purpose: avalon-mm register slave holding configuration and last vector view
// Assumes: master holds request until waitrequest is seen low
// Notes:   fixed two-cycle answer, unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none
`include "txsv_map.svh"

module txsv_regs
(
    input  wire logic               core_clk_i,
    input  wire logic               rstn_i,
    input  wire logic [3:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    input  wire logic [3:0]         avs_byteenable_i,
    input  wire logic [25:0]        last_vector_i,
    output logic [31:0]             avs_readdata_o,
    output logic                    avs_waitrequest_o,
    output txsv_pkg::txsv_cfg_t     cfg_o
);
    import txsv_pkg::*;

    logic [3:0]  ctrl;
    logic [14:0] mtu;
    logic [3:0]  next_ctrl;
    logic [14:0] next_mtu;
    logic [31:0] next_readdata;
    logic        next_wait;
    logic        req;
    logic        accept;

    // per-byte merge of write data under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // handshake and decode
    // ------------------------------------------------------------------
    // first edge of a request loads read data, the next edge accepts it
    assign req    = avs_read_i | avs_write_i;
    assign accept = req & ~avs_waitrequest_o;

    always_comb
    begin
        logic [31:0] m;
        m             = 32'h0000_0000;
        next_ctrl     = ctrl;
        next_mtu      = mtu;
        next_wait     = ~(req & avs_waitrequest_o);
        next_readdata = avs_readdata_o;
        if (req & avs_waitrequest_o)
        begin
            case (avs_address_i)
                `TXSV_CTRL_OFS: next_readdata = {28'h000_0000, ctrl};
                `TXSV_MTU_OFS:  next_readdata = {17'h0_0000, mtu};
                `TXSV_LAST_OFS: next_readdata = {6'h00, last_vector_i};
                default:        next_readdata = 32'h0000_0000;
            endcase
        end
        // writes land only on the accepting edge; unmapped ones vanish
        if (accept & avs_write_i)
        begin
            case (avs_address_i)
                `TXSV_CTRL_OFS:
                begin
                    m         = merge({28'h000_0000, ctrl}, avs_writedata_i, avs_byteenable_i);
                    next_ctrl = m[3:0];
                end
                `TXSV_MTU_OFS:
                begin
                    m        = merge({17'h0_0000, mtu}, avs_writedata_i, avs_byteenable_i);
                    next_mtu = m[14:0];
                end
                default:
                begin
                    next_ctrl = ctrl;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl              <= `TXSV_CTRL_RST;
            mtu               <= `TXSV_MTU_RST;
            avs_readdata_o    <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            ctrl              <= next_ctrl;
            mtu               <= next_mtu;
            avs_readdata_o    <= next_readdata;
            avs_waitrequest_o <= next_wait;
        end
    end

    // ------------------------------------------------------------------
    // configuration out
    // ------------------------------------------------------------------
    assign cfg_o.jumbo_en   = ctrl[`TXSV_CTRL_JUMBO];
    assign cfg_o.mtu_en     = ctrl[`TXSV_CTRL_MTU_EN];
    assign cfg_o.vlan_en    = ctrl[`TXSV_CTRL_VLAN_EN];
    assign cfg_o.inband_fcs = ctrl[`TXSV_CTRL_INBAND];
    assign cfg_o.mtu_size   = mtu;

endmodule
`default_nettype wire

// ### verilog/txsv_top.sv
// Purpose: per-frame transmit statistics vector with strobe and per-cycle byte count
// Assumes: tap and line byte count come from the same transmit clock domain
// Notes:   frame fields hold their value between strobes, byte count moves every cycle; configuration over avalon-mm
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "txsv_map.svh"

module txsv_top
(
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    input  wire txsv_pkg::txsv_tap_t tap_i,
    input  wire logic [3:0]          line_bytes_i,
    input  wire logic [3:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o,
    output logic [25:0]              stat_vector_o,
    output logic                     stat_valid_o
);
    import txsv_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // count of valid client bytes in one beat
    function automatic logic [3:0] lanes(input logic [7:0] keep);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, keep[i]};
        end
        return n;
    endfunction

    // broadcast test, shared by the broadcast and multicast flags
    function automatic logic all_ones(input logic [47:0] da);
        return &da;
    endfunction

    // clamp a running length at a 15-bit ceiling
    function automatic logic [14:0] clamp(input logic [16:0] len,
                                          input logic [14:0] lim);
        logic [14:0] r;
        if (len > {2'h0, lim})
        begin
            r = lim;
        end
        else
        begin
            r = len[14:0];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // state and next values
    // ------------------------------------------------------------------
    txsv_cfg_t   cfg;
    logic [25:0] fields;
    logic [25:0] next_fields;
    logic        next_valid;
    logic [3:0]  bytes_q;
    logic [3:0]  next_bytes;
    logic        in_frame;
    logic        second;
    logic [16:0] acc_len;
    logic        f_bcast;
    logic        f_mcast;
    logic        f_vlan;
    logic        f_ctrl;
    logic        f_under;
    logic        f_pause;
    logic        next_in_frame;
    logic        next_second;
    logic [16:0] next_acc_len;
    logic        next_bcast;
    logic        next_mcast;
    logic        next_vlan;
    logic        next_ctrl;
    logic        next_under;
    logic        next_pause;
    logic [15:0] len_type;
    logic [14:0] limit;
    logic [16:0] total;

    // ------------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------------
    txsv_regs u_regs
    (
        .core_clk_i        (core_clk_i),
        .rstn_i            (rstn_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .last_vector_i     (stat_vector_o),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .cfg_o             (cfg)
    );

    // ------------------------------------------------------------------
    // frame tracking
    // ------------------------------------------------------------------
    // length/type sits in lanes 4 and 5 of the second beat, high byte first
    assign len_type = {tap_i.data[8*`TXSV_TYPE_LANE +: 8],
                       tap_i.data[8*(`TXSV_TYPE_LANE+1) +: 8]};

    // cast flags latch on the first beat, type flags on the second; underrun, pause and length grow on every beat
    always_comb
    begin
        next_in_frame = in_frame;
        next_second   = second;
        next_acc_len  = acc_len;
        next_bcast    = f_bcast;
        next_mcast    = f_mcast;
        next_vlan     = f_vlan;
        next_ctrl     = f_ctrl;
        next_under    = f_under;
        next_pause    = f_pause;
        if (tap_i.valid)
        begin
            if (!in_frame)
            begin
                // first beat carries the destination address in lanes 0..5
                next_bcast  = all_ones(tap_i.data[47:0]);
                next_mcast  = tap_i.data[0] & ~all_ones(tap_i.data[47:0]);
                next_vlan   = 1'b0;
                next_ctrl   = 1'b0;
                next_under  = tap_i.underrun;
                next_pause  = tap_i.pause_gen;
                next_acc_len = {13'h0000, lanes(tap_i.keep)};
                next_second = 1'b1;
            end
            else
            begin
                next_under   = f_under | tap_i.underrun;
                next_pause   = f_pause | tap_i.pause_gen;
                // client bytes only; pad is added later in the pipe
                next_acc_len = acc_len + {13'h0000, lanes(tap_i.keep)};
                next_second  = 1'b0;
                if (second)
                begin
                    next_vlan = (len_type == `TXSV_TYPE_VLAN);
                    next_ctrl = (len_type == `TXSV_TYPE_CTRL);
                end
            end
            next_in_frame = ~tap_i.last;
            // guard the accumulator against overflow on very long frames
            if (next_acc_len[16])
            begin
                next_acc_len = 17'h0_ffff;
            end
        end
    end

    // registers only; every decision sits in the process above
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            in_frame <= 1'b0;
            second   <= 1'b0;
            acc_len  <= 17'h0_0000;
            f_bcast  <= 1'b0;
            f_mcast  <= 1'b0;
            f_vlan   <= 1'b0;
            f_ctrl   <= 1'b0;
            f_under  <= 1'b0;
            f_pause  <= 1'b0;
        end
        else
        begin
            in_frame <= next_in_frame;
            second   <= next_second;
            acc_len  <= next_acc_len;
            f_bcast  <= next_bcast;
            f_mcast  <= next_mcast;
            f_vlan   <= next_vlan;
            f_ctrl   <= next_ctrl;
            f_under  <= next_under;
            f_pause  <= next_pause;
        end
    end

    // ------------------------------------------------------------------
    // vector assembly on the closing beat
    // ------------------------------------------------------------------
    // saturation ceiling: mtu first, then jumbo, then standard sizes
    always_comb
    begin
        if (cfg.mtu_en)
        begin
            limit = cfg.mtu_size;
        end
        else if (cfg.jumbo_en)
        begin
            limit = `TXSV_LEN_JUMBO_MAX;
        end
        else if (next_vlan)
        begin
            limit = `TXSV_LEN_VLAN_MAX;
        end
        else
        begin
            limit = `TXSV_LEN_STD_MAX;
        end
    end

    // crc bytes are counted only when the mac appends them itself
    assign total = cfg.inband_fcs ? next_acc_len
                                  : next_acc_len + `TXSV_FCS_BYTES;

    // built from next values so a one-beat frame still reports
    always_comb
    begin
        next_fields = fields;
        next_valid  = 1'b0;
        if (tap_i.valid & tap_i.last)
        begin
            next_valid = 1'b1;
            next_fields[`TXSV_POS_PAUSE] = next_pause;
            next_fields[`TXSV_POS_VLAN]  = next_vlan & cfg.vlan_en;
            // limit is 15 bits, so every ceiling stays at or below 32767
            next_fields[`TXSV_POS_LEN_HI:`TXSV_POS_LEN_LO] =
                clamp(total, limit);
            next_fields[`TXSV_POS_CTRL]     = next_ctrl;
            next_fields[`TXSV_POS_UNDERRUN] = next_under;
            next_fields[`TXSV_POS_MCAST]    = next_mcast;
            next_fields[`TXSV_POS_BCAST]    = next_bcast;
            next_fields[`TXSV_POS_GOOD]     = ~next_under;
        end
    end

    // fields and strobe register together, so both change at one edge
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            fields       <= 26'h000_0000;
            stat_valid_o <= 1'b0;
        end
        else
        begin
            fields       <= next_fields;
            stat_valid_o <= next_valid;
        end
    end

    // ------------------------------------------------------------------
    // per-cycle byte count
    // ------------------------------------------------------------------
    // line stage count, not aligned to the frame fields
    always_comb
    begin
        next_bytes = line_bytes_i;
    end

    // own flop: moves every cycle, strobe or not
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            bytes_q <= 4'h0;
        end
        else
        begin
            bytes_q <= next_bytes;
        end
    end

    // ------------------------------------------------------------------
    // output vector: every bit from a flop, no gaps
    // ------------------------------------------------------------------
    always_comb
    begin
        stat_vector_o = fields;
        stat_vector_o[`TXSV_POS_BYTES_HI:`TXSV_POS_BYTES_LO] = bytes_q;
    end

endmodule
`default_nettype wire

// ### verification/txsv_top_sva.sv
// Purpose: port assertions for the tx statistics block
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by bind at the foot
`timescale 1ns/1ps
`default_nettype none
module txsv_top_sva
(
    input wire logic                core_clk_i,
    input wire logic                rstn_i,
    input wire txsv_pkg::txsv_tap_t tap_i,
    input wire logic [3:0]          line_bytes_i,
    input wire logic                avs_read_i,
    input wire logic                avs_write_i,
    input wire logic                avs_waitrequest_o,
    input wire logic [25:0]         stat_vector_o,
    input wire logic                stat_valid_o
);
    import txsv_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------------
    // frame end and strobe
    // ------------------------------------------------------------------
    sequence s_last;
        tap_i.valid && tap_i.last;
    endsequence
    sequence s_strobe;
        stat_valid_o;
    endsequence
    // per-frame fields only, byte count moves every cycle
    logic [21:0] fld;
    assign fld = {stat_vector_o[25], stat_vector_o[20:0]};
    // guard on past reset: byte flop still holds its reset value
    a_bytes_track: assert property ($past(rstn_i) |-> stat_vector_o[24:21] == $past(line_bytes_i))
        else $error("byte count not last cycle value");
    a_strobe_after: assert property (s_last |=> s_strobe)
        else $error("no strobe after frame end");
    a_strobe_cause: assert property (s_strobe |-> $past(tap_i.valid && tap_i.last))
        else $error("strobe without frame end");
    a_fields_hold: assert property ($past(rstn_i) && !stat_valid_o |-> $stable(fld))
        else $error("fields moved without strobe");
    a_good_flag: assert property (s_strobe |-> stat_vector_o[0] == !stat_vector_o[3])
        else $error("good flag wrong");
    a_underrun_mark: assert property (s_last ##0 tap_i.underrun |=> stat_vector_o[3])
        else $error("underrun not flagged");
    a_pause_mark: assert property (s_last ##0 tap_i.pause_gen |=> stat_vector_o[25])
        else $error("pause not flagged");
    a_cast_excl: assert property (s_strobe |-> !(stat_vector_o[1] && stat_vector_o[2]))
        else $error("broadcast also multicast");
    a_type_excl: assert property (s_strobe |-> !(stat_vector_o[4] && stat_vector_o[20]))
        else $error("control and vlan together");
    a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("no bus answer");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn_i |=> stat_vector_o == 26'h000_0000 && !stat_valid_o && avs_waitrequest_o)
        else $error("outputs not cleared by reset");
endmodule
bind txsv_top txsv_top_sva u_sva (.core_clk_i, .rstn_i, .tap_i, .line_bytes_i, .avs_read_i,
    .avs_write_i, .avs_waitrequest_o, .stat_vector_o, .stat_valid_o);
`default_nettype wire

// ### verification/txsv_stat_model.sv
// Purpose: client statistics counters fed by the vector
// Assumes: fields sampled only on strobe
// Notes:   behavioural consumer
`timescale 1ns/1ps
`default_nettype none
module txsv_stat_model
(
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic [25:0] stat_vector_i,
    input  wire logic        stat_valid_i,
    output logic [15:0]      frames_o,
    output logic [15:0]      good_o,
    output logic [31:0]      octets_o
);
    // counters move only on strobe, fields hold the last frame otherwise
    always_ff @(posedge core_clk_i)
    begin
        if (!rstn_i)
        begin
            frames_o <= 16'h0000;
            good_o   <= 16'h0000;
            octets_o <= 32'h0000_0000;
        end
        else if (stat_valid_i)
        begin
            frames_o <= frames_o + 16'h0001;
            good_o   <= good_o + {15'h0000, stat_vector_i[0]};
            octets_o <= octets_o + {17'h0_0000, stat_vector_i[19:5]};
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_txsv_top.sv
// Purpose: self-checking bench for the tx statistics block
// Assumes: one wait state on the register bus
// Notes:   random frames, seed 27, with fixed length corners
`timescale 1ns/1ps
`default_nettype none
module tb_txsv_top;
    import txsv_pkg::*;
    logic        core_clk_i = 0;
    logic        rstn_i = 0;
    txsv_tap_t   tap_i = '0;
    logic [3:0]  line_bytes_i = 0;
    logic [3:0]  avs_address_i = 0;
    logic        avs_read_i = 0;
    logic        avs_write_i = 0;
    logic [31:0] avs_writedata_i = 0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [25:0] stat_vector_o;
    logic        stat_valid_o;
    logic [15:0] m_frames;
    logic [15:0] m_good;
    logic [31:0] m_octets;
    logic [31:0] rd;
    logic [3:0]  cfg;
    logic [14:0] mtu;
    logic [25:0] last_exp;
    logic [47:0] da;
    int          failures = 0;
    int          n_checks = 0;
    int          n_frm = 0;
    int          n_good = 0;
    int          n_oct = 0;
    int          k;
    localparam logic [25:0] FMASK = 26'h21f_ffff;
    always #4 core_clk_i = ~core_clk_i;
    // line count is free-running, unrelated to the tap
    always @(posedge core_clk_i) line_bytes_i <= 4'($urandom_range(8));
    txsv_top u_dut (.core_clk_i, .rstn_i, .tap_i, .line_bytes_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .stat_vector_o, .stat_valid_o);
    txsv_stat_model u_model (.core_clk_i, .rstn_i, .stat_vector_i(stat_vector_o),
        .stat_valid_i(stat_valid_o), .frames_o(m_frames), .good_o(m_good), .octets_o(m_octets));
    // ------------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------------
    task automatic final_report;
        if (failures == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        n_checks++;
        if (e !== s)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ------------------------------------------------------------------
    // bus master, holds request until waitrequest seen low
    // ------------------------------------------------------------------
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
        int t;
        @(posedge core_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        for (t = 0; t < 20; t++)
        begin
            @(posedge core_clk_i);
            if (!avs_waitrequest_o)
                break;
        end
        q = avs_readdata_o;
        avs_read_i  <= 0;
        avs_write_i <= 0;
        if (t == 20)
        begin
            failures++;
            final_report();
        end
    endtask
    task automatic setcfg(logic [3:0] c, logic [14:0] m);
        cfg = c;
        mtu = m;
        bus(1, 4'h0, {28'h000_0000, c}, rd);
        bus(1, 4'h4, {17'h0_0000, m}, rd);
        bus(0, 4'h0, 0, rd);
        chk("ctrl", {28'h000_0000, c}, rd);
    endtask
    // expected fields from frame contents and configuration
    function automatic logic [25:0] expv(logic [47:0] d, logic [15:0] ty, int n, logic u, p);
        int ln;
        int cap;
        logic bc;
        bc = (d == 48'hffff_ffff_ffff);
        ln = n + (cfg[3] ? 0 : 4);
        cap = cfg[1] ? int'(mtu) : cfg[0] ? 'h7fff : (ty == 16'h8100) ? 'h05f2 : 'h05ee;
        if (ln > cap)
            ln = cap;
        if (ln > 'h7fff)
            ln = 'h7fff;
        expv = {p, 4'h0, ty == 16'h8100 && cfg[2], 15'(ln), ty == 16'h8808, u, d[0] && !bc, bc, !u};
    endfunction
    // ------------------------------------------------------------------
    // frame driver: lane 0 first, type in lanes 4,5 of beat 1
    // ------------------------------------------------------------------
    task automatic frame(logic [47:0] d, logic [15:0] ty, int n, logic u, p);
        int nb;
        int i;
        logic [63:0] dat;
        nb = (n + 7) / 8;
        for (i = 0; i < nb; i++)
        begin
            dat = {$urandom, $urandom};
            if (i == 0)
                dat[47:0] = d;
            if (i == 1)
                dat[47:32] = {ty[7:0], ty[15:8]};
            @(posedge core_clk_i);
            tap_i <= '{1'b1, dat, (i == nb - 1) ? 8'hff >> (8 * nb - n) : 8'hff, i == nb - 1,
                u && i == nb - 1, p && i == 0};
        end
        @(posedge core_clk_i);
        tap_i <= '0;
        #1;
        last_exp = expv(d, ty, n, u, p);
        n_frm++;
        n_good += int'(!u);
        n_oct += int'(last_exp[19:5]);
        chk("strobe", 1, stat_valid_o);
        chk("fields", last_exp & FMASK, stat_vector_o & FMASK);
    endtask
    initial
    begin
        void'($urandom(27));
        repeat (4) @(posedge core_clk_i);
        rstn_i <= 1;
        bus(0, 4'h0, 0, rd);
        chk("ctrl_rst", 0, rd);
        bus(0, 4'h4, 0, rd);
        chk("mtu_rst", 32'h0000_05ee, rd);
        bus(1, 4'hc, 32'hffff_ffff, rd);
        bus(0, 4'hc, 0, rd);
        chk("unmapped", 0, rd);
        avs_byteenable_i <= 4'he;
        bus(1, 4'h0, 32'h0000_000f, rd);
        avs_byteenable_i <= 4'hf;
        bus(0, 4'h0, 0, rd);
        chk("ctrl_be", 0, rd);
        // length ceilings exceeded, standard one also met exactly
        setcfg(4'h0, 15'h05ee);
        frame(48'hffff_ffff_ffff, 16'h0800, 1600, 0, 0);
        frame(48'h0000_0000_0001, 16'h8100, 1600, 1, 1);
        frame(48'h0000_0000_0002, 16'h0800, 1514, 0, 0);
        setcfg(4'h5, 15'h05ee);
        frame(48'h0000_0000_0001, 16'h8808, 33000, 0, 0);
        frame(48'h0000_0000_0004, 16'h8100, 200, 0, 1);
        setcfg(4'ha, 15'h0384);
        frame(48'h0000_0000_0000, 16'h0800, 1000, 0, 0);
        bus(0, 4'h8, 0, rd);
        chk("last_vec", {6'h00, last_exp & FMASK}, rd & {6'h00, FMASK});
        for (k = 0; k < 48; k++)
        begin
            if (k % 8 == 0)
                setcfg(4'($urandom), 15'($urandom_range(1600, 64)));
            da = {$urandom, 16'($urandom)};
            if (k % 3 == 2)
                da = '1;
            frame(da, k % 4 == 0 ? 16'h8100 : k % 4 == 1 ? 16'h8808 : 16'h0800,
                $urandom_range(1700, 14), 1'($urandom), 1'($urandom));
        end
        repeat (2) @(posedge core_clk_i);
        chk("frames", n_frm, m_frames);
        chk("good", n_good, m_good);
        chk("octets", n_oct, m_octets);
        final_report();
    end
endmodule
`default_nettype wire
